// File: hdl/dteie_pkg.sv
// Contract
// - descriptor-table load/store exits use the layout with a one-bit operand size.
// - local-table and task load/store exits use the layout with memory/register flag.
// - bits 1:0 hold index scaling, codes 0..3 for x1, x2, x4, x8.
// - first layout leaves scaling undefined when bit 22 marks no index.
// - bits 9:7 hold address size, 0 16-bit, 1 32-bit, 2 64-bit only.
// - first layout clears bit 10; bit 11 is operand size, undefined in 64-bit mode.
// - bits 17:15 hold segment code 0..5; codes 6 and 7 never appear.
// - bits 21:18 hold index register number 0..15.
// - bit 22 set when no index register, clear when index valid.
// - bits 26:23 hold base register; bit 27 set when no base register.
// - first layout bits 29:28: store-global, store-interrupt, load-global, load-interrupt.
// - second layout bit 10 is one for register operand, zero for memory.
// - second layout scaling undefined for register operands or missing index.
// - second layout bits 6:3 hold register operand number, undefined for memory.
// - second layout address size and segment undefined for register operands.
// - second layout index, base and their invalid bits only for memory operands.
// - second layout base register uses the register-operand encoding.
// - second layout bits 29:28: store-local, store-task, load-local, load-task.
package dteie_pkg;
	localparam logic [11:0] DTEIE_DESC_INFO_OFF = 12'h000;
	localparam logic [11:0] DTEIE_LOCAL_INFO_OFF = 12'h004;
	localparam logic [11:0] DTEIE_CTRL_OFF = 12'h008;
	localparam logic [11:0] DTEIE_STATUS_OFF = 12'h00c;
	localparam logic [31:0] DTEIE_INFO_RST = 32'h0000_0000;
	localparam int DTEIE_SCALE_LSB = 0;
	localparam int DTEIE_OPREG_LSB = 3;
	localparam int DTEIE_ASIZE_LSB = 7;
	localparam int DTEIE_MEMREG_BIT = 10;
	localparam int DTEIE_OPSIZE_BIT = 11;
	localparam int DTEIE_SEG_LSB = 15;
	localparam int DTEIE_IDX_LSB = 18;
	localparam int DTEIE_IDXINV_BIT = 22;
	localparam int DTEIE_BASE_LSB = 23;
	localparam int DTEIE_BASEINV_BIT = 27;
	localparam int DTEIE_IDENT_LSB = 28;
	localparam logic [2:0] DTEIE_SEG_MAX = 3'h5;
	localparam logic [2:0] DTEIE_ASIZE_MAX = 3'h2;
	typedef enum logic [2:0] {
		DTEIE_STORE_GLOBAL = 3'b000,
		DTEIE_STORE_INTR = 3'b001,
		DTEIE_LOAD_GLOBAL = 3'b010,
		DTEIE_LOAD_INTR = 3'b011,
		DTEIE_STORE_LOCAL = 3'b100,
		DTEIE_STORE_TASK = 3'b101,
		DTEIE_LOAD_LOCAL = 3'b110,
		DTEIE_LOAD_TASK = 3'b111
	} dteie_instr_t;
	typedef struct packed {
		logic [1:0] scale;
		logic [2:0] addr_size;
		logic op_size;
		logic reg_operand;
		logic [3:0] operand_gpr_field;
		logic [2:0] segment;
		logic [3:0] index_gpr_field;
		logic index_valid;
		logic [3:0] base_gpr_field;
		logic base_valid;
		logic mode64;
	} dteie_operand_t;
endpackage

// File: hdl/dteie_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dteie_if;
	import dteie_pkg::*;
	logic [2:0] instr;
	dteie_operand_t opnd;
	logic [31:0] word;
	logic is_local;
	modport producer (output instr, output opnd, input word, input is_local);
	modport encoder (input instr, input opnd, output word, output is_local);
endinterface
`default_nettype wire

// File: hdl/dteie_word_enc.sv
`timescale 1ns/10ps
`default_nettype none
module dteie_word_enc
	import dteie_pkg::*;
(
	dteie_if.encoder enc
);
	function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] mx);
		clamp3 = (v > mx) ? mx : v;
	endfunction

	always_comb begin
		logic [31:0] w;
		logic mem;
		w = 32'h0000_0000;
		mem = !(enc.instr[2] && enc.opnd.reg_operand);
		enc.is_local = enc.instr[2];
		// undefined bits are driven to zero
		if (mem) begin
			w[DTEIE_ASIZE_LSB +: 3] = clamp3(enc.opnd.addr_size, DTEIE_ASIZE_MAX);
			w[DTEIE_SEG_LSB +: 3] = clamp3(enc.opnd.segment, DTEIE_SEG_MAX);
			w[DTEIE_IDXINV_BIT] = !enc.opnd.index_valid;
			if (enc.opnd.index_valid) begin
				w[DTEIE_IDX_LSB +: 4] = enc.opnd.index_gpr_field;
				w[DTEIE_SCALE_LSB +: 2] = enc.opnd.scale;
			end
			w[DTEIE_BASEINV_BIT] = !enc.opnd.base_valid;
			if (enc.opnd.base_valid)
				w[DTEIE_BASE_LSB +: 4] = enc.opnd.base_gpr_field;
		end
		if (enc.is_local) begin
			w[DTEIE_MEMREG_BIT] = !mem;
			if (!mem)
				w[DTEIE_OPREG_LSB +: 4] = enc.opnd.operand_gpr_field;
		end else begin
			w[DTEIE_MEMREG_BIT] = 1'b0;
			if (!enc.opnd.mode64)
				w[DTEIE_OPSIZE_BIT] = enc.opnd.op_size;
		end
		w[DTEIE_IDENT_LSB +: 2] = enc.instr[1:0];
		enc.word = w;
	end
endmodule // dteie_word_enc
`default_nettype wire

// File: hdl/dteie_top.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dteie_top
	import dteie_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic exit_valid,
	input wire logic [2:0] exit_instr,
	input wire logic [1:0] exit_scale,
	input wire logic [2:0] exit_addr_size,
	input wire logic exit_op_size,
	input wire logic exit_reg_operand,
	input wire logic [3:0] exit_operand_gpr,
	input wire logic [2:0] exit_segment,
	input wire logic [3:0] exit_index_gpr,
	input wire logic exit_index_valid,
	input wire logic [3:0] exit_base_gpr,
	input wire logic exit_base_valid,
	input wire logic exit_mode64,
	output logic [31:0] info_word,
	output logic info_local,
	output logic info_valid
);
	typedef struct packed {
		logic [31:0] desc_info;
		logic [31:0] local_info;
		logic [31:0] prdata;
		logic pslverr;
		logic capture_en;
		logic desc_new;
		logic local_new;
		logic [31:0] info_word;
		logic info_local;
		logic info_valid;
		logic pend;
	} dteie_state_t;

	dteie_state_t st_ff;
	dteie_state_t nxt_st;
	dteie_if enc_bus ();

	assign enc_bus.instr = exit_instr;
	assign enc_bus.opnd = '{scale: exit_scale, addr_size: exit_addr_size,
		op_size: exit_op_size, reg_operand: exit_reg_operand,
		operand_gpr_field: exit_operand_gpr, segment: exit_segment,
		index_gpr_field: exit_index_gpr, index_valid: exit_index_valid,
		base_gpr_field: exit_base_gpr, base_valid: exit_base_valid,
		mode64: exit_mode64};

	dteie_word_enc u_enc (
		.enc(enc_bus.encoder)
	);

	always_comb begin
		logic acc;
		logic take;
		logic opening;
		logic closing;
		acc = psel && penable;
		take = exit_valid && st_ff.capture_en;
		// read data and read-clears at the first access edge, writes at the pready edge
		opening = acc && !st_ff.pend;
		closing = acc && st_ff.pend;
		nxt_st = st_ff;
		nxt_st.pslverr = 1'b0;
		nxt_st.pend = opening;
		if (take) begin
			nxt_st.info_word = enc_bus.word;
			nxt_st.info_local = enc_bus.is_local;
			if (enc_bus.is_local) begin
				nxt_st.local_info = enc_bus.word;
			end else begin
				nxt_st.desc_info = enc_bus.word;
			end
		end
		nxt_st.info_valid = take;
		if (opening) begin
			nxt_st.prdata = 32'h0000_0000;
			case (paddr)
				DTEIE_DESC_INFO_OFF: begin
					if (!pwrite) begin
						nxt_st.prdata = st_ff.desc_info;
						nxt_st.desc_new = 1'b0;
					end else begin
						nxt_st.pslverr = 1'b1;
					end
				end
				DTEIE_LOCAL_INFO_OFF: begin
					if (!pwrite) begin
						nxt_st.prdata = st_ff.local_info;
						nxt_st.local_new = 1'b0;
					end else begin
						nxt_st.pslverr = 1'b1;
					end
				end
				DTEIE_CTRL_OFF: begin
					if (!pwrite)
						nxt_st.prdata = {31'h0, st_ff.capture_en};
				end
				DTEIE_STATUS_OFF: begin
					if (!pwrite)
						nxt_st.prdata = {30'h0, st_ff.local_new, st_ff.desc_new};
					else
						nxt_st.pslverr = 1'b1;
				end
				default: begin
					nxt_st.pslverr = 1'b1;
				end
			endcase
		end
		if (closing && pwrite && paddr == DTEIE_CTRL_OFF)
			nxt_st.capture_en = pwdata[0];
		// a new capture wins over a read-clear
		if (take && enc_bus.is_local)
			nxt_st.local_new = 1'b1;
		if (take && !enc_bus.is_local)
			nxt_st.desc_new = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '{desc_info: DTEIE_INFO_RST, local_info: DTEIE_INFO_RST,
				prdata: 32'h0000_0000, pslverr: 1'b0, capture_en: 1'b1,
				desc_new: 1'b0, local_new: 1'b0, info_word: DTEIE_INFO_RST,
				info_local: 1'b0, info_valid: 1'b0, pend: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// answer one cycle after the access phase opens
	assign pready = st_ff.pend;
	assign prdata = st_ff.prdata;
	assign pslverr = st_ff.pend && st_ff.pslverr;
	assign info_word = st_ff.info_word;
	assign info_local = st_ff.info_local;
	assign info_valid = st_ff.info_valid;
endmodule // dteie_top
`default_nettype wire

// File: bench/dteie_props.sv
`timescale 1ns/10ps
`default_nettype none
module dteie_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic exit_valid,
	input wire logic [2:0] exit_instr,
	input wire logic exit_reg_operand,
	input wire logic exit_index_valid,
	input wire logic exit_base_valid,
	input wire logic [31:0] info_word,
	input wire logic info_local,
	input wire logic info_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic mem_form = !(info_local && info_word[10]);
	a_valid_after_exit: assert property (info_valid |-> $past(exit_valid)) else $error("stray info_valid");
	a_word_held: assert property (!info_valid |-> $stable(info_word)) else $error("word changed");
	a_layout_pick: assert property (info_valid |-> info_local == $past(exit_instr[2])) else $error("layout");
	a_ident_field: assert property (info_valid |-> info_word[29:28] == $past(exit_instr[1:0])) else $error("ident");
	a_bit10_clear: assert property (info_valid && !info_local |-> !info_word[10]) else $error("bit10 set");
	a_regflag_copy: assert property (info_valid && info_local |-> info_word[10] == $past(exit_reg_operand)) else $error("flag");
	a_index_inval: assert property (info_valid && mem_form |-> info_word[22] == !$past(exit_index_valid)) else $error("idx");
	a_base_inval: assert property (info_valid && mem_form |-> info_word[27] == !$past(exit_base_valid)) else $error("base");
	a_code_range: assert property (info_valid && mem_form |-> info_word[17:15] <= 3'h5 && info_word[9:7] <= 3'h2) else $error("range");
	a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready) else $error("apb timing");
	c_first: cover property (info_valid && !info_local);
	c_second: cover property (info_valid && info_local && info_word[10]);
	c_err: cover property (pready && pslverr);
endmodule // dteie_props
bind dteie_top dteie_props dteie_props_inst (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .exit_valid,
	.exit_instr, .exit_reg_operand, .exit_index_valid, .exit_base_valid, .info_word, .info_local, .info_valid);
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
	import dteie_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, exit_valid = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, info_word, rd;
	logic pready, pslverr, info_local, info_valid, er;
	logic [2:0] exit_instr = 3'h0;
	dteie_operand_t op = '0;
	int fail_count = 0, compares = 0;
	dteie_top dteie_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .exit_valid, .exit_instr, .exit_scale(op.scale), .exit_addr_size(op.addr_size),
		.exit_op_size(op.op_size), .exit_reg_operand(op.reg_operand), .exit_operand_gpr(op.operand_gpr_field),
		.exit_segment(op.segment), .exit_index_gpr(op.index_gpr_field), .exit_index_valid(op.index_valid),
		.exit_base_gpr(op.base_gpr_field), .exit_base_valid(op.base_valid), .exit_mode64(op.mode64),
		.info_word, .info_local, .info_valid);
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic take_exit(input logic [2:0] ins, input dteie_operand_t o);
		exit_instr <= ins;
		op <= o;
		exit_valid <= 1'b1;
		@(posedge pclk);
		exit_valid <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] enc(input logic [2:0] ins, input dteie_operand_t o);
		logic [31:0] w;
		w = 32'h0;
		if (!(ins[2] && o.reg_operand)) begin
			w[9:7] = (o.addr_size > DTEIE_ASIZE_MAX) ? DTEIE_ASIZE_MAX : o.addr_size;
			w[17:15] = (o.segment > DTEIE_SEG_MAX) ? DTEIE_SEG_MAX : o.segment;
			w[22] = !o.index_valid;
			w[27] = !o.base_valid;
			if (o.index_valid) w[21:18] = o.index_gpr_field;
			if (o.index_valid) w[1:0] = o.scale;
			if (o.base_valid) w[26:23] = o.base_gpr_field;
		end
		if (ins[2]) w[10] = o.reg_operand;
		if (ins[2] && o.reg_operand) w[6:3] = o.operand_gpr_field;
		if (!ins[2]) w[11] = o.op_size && !o.mode64;
		w[29:28] = ins[1:0];
		return w;
	endfunction
	task automatic t_layouts();
		dteie_operand_t o;
		for (int i = 0; i < 8; i++) begin
			o = '{i[1:0], 3'(i % 3), i[0], i[0], 4'(i + 8), 3'(i % 6), 4'(15 - i), i != 2, 4'(i), i != 5, i == 3};
			take_exit(3'(i), o);
			chk({31'h0, info_valid}, 32'h1);
			chk(info_word, enc(3'(i), o));
			apb(1'b0, i[2] ? DTEIE_LOCAL_INFO_OFF : DTEIE_DESC_INFO_OFF, 32'h0);
			chk({31'h0, info_local}, {31'h0, i[2]});
			chk(rd, enc(3'(i), o));
			chk({31'h0, er}, 32'h0);
		end
	endtask
	task automatic t_status();
		dteie_operand_t o;
		o = '0;
		o.addr_size = 3'h7;
		o.segment = 3'h6;
		o.scale = 2'h3;
		o.index_gpr_field = 4'h9;
		o.base_gpr_field = 4'h4;
		take_exit(DTEIE_LOAD_LOCAL, o);
		chk(info_word, enc(DTEIE_LOAD_LOCAL, o));
		chk({31'h0, info_local}, 32'h1);
		apb(1'b0, DTEIE_STATUS_OFF, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, DTEIE_LOCAL_INFO_OFF, 32'h0);
		chk(rd, enc(DTEIE_LOAD_LOCAL, o));
		chk({31'h0, er}, 32'h0);
		apb(1'b0, DTEIE_STATUS_OFF, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_regs();
		apb(1'b0, DTEIE_CTRL_OFF, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, DTEIE_DESC_INFO_OFF, 32'hffff_ffff);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, DTEIE_DESC_INFO_OFF, 32'h0);
		chk(rd, DTEIE_INFO_RST);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, DTEIE_CTRL_OFF, 32'h0);
		take_exit(3'h3, '0);
		chk({31'h0, info_valid}, 32'h0);
		apb(1'b1, DTEIE_CTRL_OFF, 32'h1);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_layouts();
		t_status();
		final_report();
	end
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule // tb
`default_nettype wire
